// ==== core/nfcb_pkg.sv ====
package nfcb_pkg;

  localparam int CLK_MHZ = 100;

  // pin timing in ns; cycle counts round up to whole clocks
  localparam int RESET_LOW_MIN_TIME_NS = 100;
  localparam int RESET_TO_WRITE_TIME_NS = 210;
  localparam int RESET_TO_READ_TIME_NS = 210;
  localparam int WRITE_LOW_NS = 70;
  localparam int READ_ACCESS_NS = 120;

  localparam int RESET_LOW_CYC = (RESET_LOW_MIN_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_WRITE_CYC =
    (RESET_TO_WRITE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_READ_CYC = (RESET_TO_READ_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_WAIT_CYC =
    (RESET_WRITE_CYC > RESET_READ_CYC) ? RESET_WRITE_CYC : RESET_READ_CYC;
  localparam int WRITE_LOW_CYC = (WRITE_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int READ_ACCESS_CYC = (READ_ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int SYNC_STAGES = 2;

  // command codes on the data bus
  localparam logic [15:0] CMD_SET_PAGE = 16'h0060;
  localparam logic [15:0] CMD_CONFIRM_PAGE = 16'h0004;
  localparam logic [15:0] CMD_CLEAR_STATUS = 16'h0050;

  // page length config value
  localparam int CFG_PAGE_BIT = 13;
  localparam logic [15:0] CFG_PAGE_MASK = 16'h2000;
  localparam logic [15:0] CFG_RESET = 16'h0000;

  // chip select patterns {cs2, cs1, cs0}
  localparam logic [2:0] CS_SELECT = 3'h0;
  localparam logic [2:0] CS_DESELECT = 3'h1;

  // controller register offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_CFG = 8'h0c;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_CTRL = 8'h18;

  localparam int CMD_OP_LSB = 0;
  localparam int CTRL_PROGRAM_ENABLE_VOLTAGE_BIT = 0;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DEV_BUSY_BIT = 1;
  localparam int ST_PAGE8_BIT = 2;
  localparam int ST_PROGRAM_ENABLE_VOLTAGE_BIT = 3;
  localparam int ST_RESET_BIT = 4;

  typedef enum logic [1:0] {
    OP_WRITE    = 2'b00,
    OP_READ     = 2'b01,
    OP_SET_PAGE = 2'b10,
    OP_RESET    = 2'b11
  } nfcb_op_t;

  typedef enum logic [2:0] {
    S_RST_LOW  = 3'b000,
    S_RST_WAIT = 3'b001,
    S_IDLE     = 3'b010,
    S_SINGLE   = 3'b011,
    S_CFG1     = 3'b100,
    S_CFG2     = 3'b101,
    S_CLEAR    = 3'b110
  } nfcb_seq_t;

  typedef enum logic [1:0] {
    E_IDLE   = 2'b00,
    E_SETUP  = 2'b01,
    E_STROBE = 2'b10,
    E_HOLD   = 2'b11
  } nfcb_eng_t;

endpackage

// ==== core/nfcb_cyc_if.sv ====
interface nfcb_cyc_if #(
  parameter int ADDR_W = 24
);
  logic              req;
  logic              rd;
  logic [ADDR_W-1:0] addr;
  logic [15:0]       wdata;
  logic              done;
  logic [15:0]       rdata;

  modport seq (output req, rd, addr, wdata, input done, rdata);
  modport eng (input req, rd, addr, wdata, output done, rdata);
endinterface

// ==== core/nfcb_bus_cycle.sv ====
module nfcb_bus_cycle #(
  parameter int ADDR_W = 24
) (
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  nfcb_cyc_if.eng                cyc,
  input  wire logic [15:0]       dq_i,
  output logic      [ADDR_W-1:0] addr_o,
  output logic      [15:0]       dq_o,
  output logic                   dq_oe_n_o,
  output logic      [2:0]        chip_selects_o,
  output logic                   out_en_n_o,
  output logic                   write_en_n_o
);

  typedef struct packed {
    nfcb_pkg::nfcb_eng_t st;
    logic [15:0]         cnt;
    logic                rd;
    logic [ADDR_W-1:0]   addr;
    logic [15:0]         dq;
    logic                dq_oe_n;
    logic [2:0]          cs;
    logic                oe_n;
    logic                we_n;
    logic                done;
    logic [15:0]         rdata;
    logic [15:0]         sync1;
    logic [15:0]         sync2;
  } nfcb_eng_state_t;

  nfcb_eng_state_t s;
  nfcb_eng_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.sync1 = dq_i;
    next_s.sync2 = s.sync1;
    unique case (s.st)
      nfcb_pkg::E_IDLE: begin
        if (cyc.req) begin
          next_s.addr = cyc.addr;
          next_s.rd = cyc.rd;
          next_s.cs = nfcb_pkg::CS_SELECT;
          if (!cyc.rd) begin
            next_s.dq = cyc.wdata;
            next_s.dq_oe_n = 1'b0;
          end
          next_s.st = nfcb_pkg::E_SETUP;
        end
      end
      nfcb_pkg::E_SETUP: begin
        // never both strobes low at once
        if (s.rd) begin
          next_s.oe_n = 1'b0;
          next_s.cnt = 16'(nfcb_pkg::READ_ACCESS_CYC +
                           nfcb_pkg::SYNC_STAGES - 1);
        end else begin
          next_s.we_n = 1'b0;
          next_s.cnt = 16'(nfcb_pkg::WRITE_LOW_CYC - 1);
        end
        next_s.st = nfcb_pkg::E_STROBE;
      end
      nfcb_pkg::E_STROBE: begin
        if (s.cnt == 16'h0000) begin
          if (s.rd) begin
            next_s.rdata = s.sync2;
            next_s.oe_n = 1'b1;
          end else begin
            // data latched on the rising write strobe, held one more cycle
            next_s.we_n = 1'b1;
          end
          next_s.st = nfcb_pkg::E_HOLD;
        end else begin
          next_s.cnt = s.cnt - 16'h0001;
        end
      end
      nfcb_pkg::E_HOLD: begin
        next_s.cs = nfcb_pkg::CS_DESELECT;
        next_s.dq_oe_n = 1'b1;
        next_s.done = 1'b1;
        next_s.st = nfcb_pkg::E_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s <= '{st: nfcb_pkg::E_IDLE, cnt: 16'h0000, rd: 1'b0, addr: '0,
             dq: 16'h0000, dq_oe_n: 1'b1, cs: nfcb_pkg::CS_DESELECT,
             oe_n: 1'b1, we_n: 1'b1, done: 1'b0, rdata: 16'h0000,
             sync1: 16'h0000, sync2: 16'h0000};
    end else begin
      s <= next_s;
    end
  end

  assign cyc.done = s.done;
  assign cyc.rdata = s.rdata;
  assign addr_o = s.addr;
  assign dq_o = s.dq;
  assign dq_oe_n_o = s.dq_oe_n;
  assign chip_selects_o = s.cs;
  assign out_en_n_o = s.oe_n;
  assign write_en_n_o = s.we_n;

endmodule // nfcb_bus_cycle

// ==== core/nfcb_flash_host.sv ====
//Contract
// - config value travels on address bits 15:0
// - two writes 0060h then 0004h, same address
// - host writes zero to reserved config bits
// - eight-word mode needs clear status afterwards
// - write latched on rising write enable
// - reset held low minimum, then read wait
// - wait reset-to-write before any command
// - flash reset follows processor reset
// - host supplies target address with commands
//
// The register addresses and the plain strobed port were decided locally.
module nfcb_flash_host #(
  parameter int ADDR_W = 24
) (
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  input  wire logic [7:0]        reg_addr_i,
  input  wire logic [31:0]       reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [31:0]       reg_rdata_o,
  output logic      [ADDR_W-1:0] flash_addr_o,
  output logic      [15:0]       flash_dq_o,
  input  wire logic [15:0]       flash_dq_i,
  output logic                   flash_dq_oe_n_o,
  output logic      [2:0]        chip_selects_o,
  output logic                   out_en_n_o,
  output logic                   write_en_n_o,
  output logic                   reset_powerdown_n_o,
  output logic                   program_enable_o,
  input  wire logic              busy_status_pin_i
);

  if (ADDR_W < 17 || ADDR_W > 32) begin : g_check
    $error("nfcb_flash_host: ADDR_W must lie in 17..32");
  end

  typedef struct packed {
    nfcb_pkg::nfcb_seq_t st;
    logic [15:0]         cnt;
    logic                req;
    logic                rd;
    logic [ADDR_W-1:0]   cyc_addr;
    logic [15:0]         cyc_wdata;
    logic [ADDR_W-1:0]   addr;
    logic [15:0]         wdata;
    logic [15:0]         cfg;
    logic [15:0]         rdata;
    logic                page8;
    logic                program_enable_voltage;
    logic                rst_pin_n;
    logic                sts1;
    logic                sts2;
    logic [31:0]         reg_rdata;
  } nfcb_host_state_t;

  nfcb_host_state_t s;
  nfcb_host_state_t next_s;
  logic [15:0]      cfg_clean;
  logic [31:0]      status_word;

  nfcb_cyc_if #(.ADDR_W(ADDR_W)) cyc ();

  assign cyc.req = s.req;
  assign cyc.rd = s.rd;
  assign cyc.addr = s.cyc_addr;
  assign cyc.wdata = s.cyc_wdata;

  // reserved positions forced to zero
  assign cfg_clean = s.cfg & nfcb_pkg::CFG_PAGE_MASK;

  assign status_word = {27'h000_0000, !s.rst_pin_n, s.program_enable_voltage, s.page8,
                        !s.sts2, s.st != nfcb_pkg::S_IDLE};

  always_comb begin
    next_s = s;
    next_s.req = 1'b0;
    next_s.reg_rdata = 32'h0000_0000;
    next_s.sts1 = busy_status_pin_i;
    next_s.sts2 = s.sts1;
    unique case (s.st)
      nfcb_pkg::S_RST_LOW: begin
        if (s.cnt == 16'h0000) begin
          next_s.rst_pin_n = 1'b1;
          next_s.cnt = 16'(nfcb_pkg::RESET_WAIT_CYC - 1);
          next_s.st = nfcb_pkg::S_RST_WAIT;
        end else begin
          next_s.cnt = s.cnt - 16'h0001;
        end
      end
      nfcb_pkg::S_RST_WAIT: begin
        if (s.cnt == 16'h0000) begin
          next_s.page8 = 1'b0;
          next_s.st = nfcb_pkg::S_IDLE;
        end else begin
          next_s.cnt = s.cnt - 16'h0001;
        end
      end
      nfcb_pkg::S_IDLE: begin
      end
      nfcb_pkg::S_SINGLE: begin
        if (cyc.done) begin
          if (s.rd) begin
            next_s.rdata = cyc.rdata;
          end
          next_s.st = nfcb_pkg::S_IDLE;
        end
      end
      nfcb_pkg::S_CFG1: begin
        if (cyc.done) begin
          next_s.req = 1'b1;
          next_s.cyc_addr = {s.addr[ADDR_W-1:16], cfg_clean};
          next_s.cyc_wdata = nfcb_pkg::CMD_CONFIRM_PAGE;
          next_s.st = nfcb_pkg::S_CFG2;
        end
      end
      nfcb_pkg::S_CFG2: begin
        if (cyc.done) begin
          next_s.page8 = cfg_clean[nfcb_pkg::CFG_PAGE_BIT];
          if (cfg_clean[nfcb_pkg::CFG_PAGE_BIT]) begin
            next_s.req = 1'b1;
            next_s.cyc_addr = s.addr;
            next_s.cyc_wdata = nfcb_pkg::CMD_CLEAR_STATUS;
            next_s.st = nfcb_pkg::S_CLEAR;
          end else begin
            next_s.st = nfcb_pkg::S_IDLE;
          end
        end
      end
      nfcb_pkg::S_CLEAR: begin
        if (cyc.done) begin
          next_s.st = nfcb_pkg::S_IDLE;
        end
      end
      default: begin
        next_s.st = nfcb_pkg::S_IDLE;
      end
    endcase

    if (reg_wr_i) begin
      unique case (reg_addr_i)
        nfcb_pkg::REG_ADDR: next_s.addr = reg_wdata_i[ADDR_W-1:0];
        nfcb_pkg::REG_WDATA: next_s.wdata = reg_wdata_i[15:0];
        nfcb_pkg::REG_CFG: next_s.cfg = reg_wdata_i[15:0];
        nfcb_pkg::REG_CTRL: next_s.program_enable_voltage = reg_wdata_i[nfcb_pkg::CTRL_PROGRAM_ENABLE_VOLTAGE_BIT];
        nfcb_pkg::REG_CMD: begin
          // orders while busy are dropped
          if (s.st == nfcb_pkg::S_IDLE) begin
            unique case (nfcb_pkg::nfcb_op_t'(reg_wdata_i[1:0]))
              nfcb_pkg::OP_WRITE: begin
                next_s.req = 1'b1;
                next_s.rd = 1'b0;
                next_s.cyc_addr = s.addr;
                next_s.cyc_wdata = s.wdata;
                next_s.st = nfcb_pkg::S_SINGLE;
              end
              nfcb_pkg::OP_READ: begin
                next_s.req = 1'b1;
                next_s.rd = 1'b1;
                next_s.cyc_addr = s.addr;
                next_s.st = nfcb_pkg::S_SINGLE;
              end
              nfcb_pkg::OP_SET_PAGE: begin
                next_s.req = 1'b1;
                next_s.rd = 1'b0;
                next_s.cyc_addr = {s.addr[ADDR_W-1:16], cfg_clean};
                next_s.cyc_wdata = nfcb_pkg::CMD_SET_PAGE;
                next_s.st = nfcb_pkg::S_CFG1;
              end
              nfcb_pkg::OP_RESET: begin
                next_s.rst_pin_n = 1'b0;
                next_s.cnt = 16'(nfcb_pkg::RESET_LOW_CYC - 1);
                next_s.st = nfcb_pkg::S_RST_LOW;
              end
            endcase
          end
        end
        default: begin
        end
      endcase
    end

    if (reg_rd_i) begin
      unique case (reg_addr_i)
        nfcb_pkg::REG_ADDR: next_s.reg_rdata = 32'(s.addr);
        nfcb_pkg::REG_WDATA: next_s.reg_rdata = {16'h0000, s.wdata};
        nfcb_pkg::REG_CFG: next_s.reg_rdata = {16'h0000, s.cfg};
        nfcb_pkg::REG_RDATA: next_s.reg_rdata = {16'h0000, s.rdata};
        nfcb_pkg::REG_STATUS: next_s.reg_rdata = status_word;
        nfcb_pkg::REG_CTRL: next_s.reg_rdata = {31'h0000_0000, s.program_enable_voltage};
        default: next_s.reg_rdata = 32'h0000_0000;
      endcase
    end
  end

  // flash reset pin held low from the host's own reset
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s <= '{st: nfcb_pkg::S_RST_LOW,
             cnt: 16'(nfcb_pkg::RESET_LOW_CYC - 1),
             req: 1'b0, rd: 1'b0, cyc_addr: '0, cyc_wdata: 16'h0000,
             addr: '0, wdata: 16'h0000, cfg: nfcb_pkg::CFG_RESET,
             rdata: 16'h0000, page8: 1'b0, program_enable_voltage: 1'b0,
             rst_pin_n: 1'b0, sts1: 1'b1, sts2: 1'b1,
             reg_rdata: 32'h0000_0000};
    end else begin
      s <= next_s;
    end
  end

  nfcb_bus_cycle #(.ADDR_W(ADDR_W)) u_cycle (
    .clk_i          (clk_i),
    .reset_n_i      (reset_n_i),
    .cyc            (cyc.eng),
    .dq_i           (flash_dq_i),
    .addr_o         (flash_addr_o),
    .dq_o           (flash_dq_o),
    .dq_oe_n_o      (flash_dq_oe_n_o),
    .chip_selects_o (chip_selects_o),
    .out_en_n_o     (out_en_n_o),
    .write_en_n_o   (write_en_n_o)
  );

  assign reg_rdata_o = s.reg_rdata;
  assign reset_powerdown_n_o = s.rst_pin_n;
  assign program_enable_o = s.program_enable_voltage;

endmodule // nfcb_flash_host

// ==== tb/nfcb_asserts.sv ====
module nfcb_asserts #(
  parameter int ADDR_W = 24
) (
  input wire logic              clk_i,
  input wire logic              reset_n_i,
  input wire logic [ADDR_W-1:0] flash_addr_o,
  input wire logic [15:0]       flash_dq_o,
  input wire logic              flash_dq_oe_n_o,
  input wire logic [2:0]        chip_selects_o,
  input wire logic              out_en_n_o,
  input wire logic              write_en_n_o,
  input wire logic              reset_powerdown_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  lo_cnt;
  logic [7:0]  hi_cnt;
  logic [15:0] setup_addr;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);
  // saturating counts of flash reset low and high time
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lo_cnt <= 8'h00;
      hi_cnt <= 8'h00;
      setup_addr <= 16'h0000;
    end else begin
      lo_cnt <= reset_powerdown_n_o ? 8'h00 : lo_cnt + {7'h00, ~&lo_cnt};
      hi_cnt <= reset_powerdown_n_o ? hi_cnt + {7'h00, ~&hi_cnt} : 8'h00;
      if ($fell(write_en_n_o) && flash_dq_o == nfcb_pkg::CMD_SET_PAGE)
        setup_addr <= flash_addr_o[15:0];
    end
  end
  a_oe_we_apart:
    assert property (!(!out_en_n_o && !write_en_n_o))
    else $error("oe and we low together");
  a_dq_drive_write:
    assert property (!write_en_n_o |-> !flash_dq_oe_n_o)
    else $error("data not driven during write strobe");
  a_dq_float_read:
    assert property (!out_en_n_o |-> flash_dq_oe_n_o)
    else $error("host drives data during read");
  a_we_selected:
    assert property (!write_en_n_o |-> chip_selects_o ==
      nfcb_pkg::CS_SELECT && $stable(flash_dq_o) && $stable(flash_addr_o))
    else $error("write strobe without stable select or data");
  a_we_low_width:
    assert property ($fell(write_en_n_o) |->
      !write_en_n_o [*7] ##1 write_en_n_o)
    else $error("write strobe width wrong");
  a_reset_low_min:
    assert property ($rose(reset_powerdown_n_o) |->
      lo_cnt >= nfcb_pkg::RESET_LOW_CYC)
    else $error("flash reset pulse too short");
  a_write_wait:
    assert property ($fell(write_en_n_o) |->
      hi_cnt >= nfcb_pkg::RESET_WRITE_CYC)
    else $error("write too soon after flash reset");
  a_read_wait:
    assert property ($fell(out_en_n_o) |->
      hi_cnt >= nfcb_pkg::RESET_READ_CYC)
    else $error("read too soon after flash reset");
  a_cfg_reserved:
    assert property ($fell(write_en_n_o) && flash_dq_o ==
      nfcb_pkg::CMD_SET_PAGE |-> (flash_addr_o[15:0] &
      ~nfcb_pkg::CFG_PAGE_MASK) == 16'h0000)
    else $error("reserved config bits set");
  a_cfg_confirm:
    assert property ($fell(write_en_n_o) && flash_dq_o ==
      nfcb_pkg::CMD_SET_PAGE |-> ##[5:40] ($fell(write_en_n_o) &&
      flash_dq_o == nfcb_pkg::CMD_CONFIRM_PAGE &&
      flash_addr_o[15:0] == setup_addr))
    else $error("config confirm missing or moved");
endmodule // nfcb_asserts

bind nfcb_flash_host nfcb_asserts #(.ADDR_W(ADDR_W)) u_asserts (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .flash_addr_o(flash_addr_o),
  .flash_dq_o(flash_dq_o), .flash_dq_oe_n_o(flash_dq_oe_n_o),
  .chip_selects_o(chip_selects_o),
  .out_en_n_o(out_en_n_o), .write_en_n_o(write_en_n_o),
  .reset_powerdown_n_o(reset_powerdown_n_o));

// ==== tb/nfcb_flash_model.sv ====
module nfcb_flash_model (
  input  wire logic        clk_i,
  input  wire logic [23:0] addr_i,
  input  wire logic [15:0] dq_i,
  input  wire logic [2:0]  chip_selects_i,
  input  wire logic        out_en_n_i,
  input  wire logic        write_en_n_i,
  input  wire logic        reset_powerdown_n_i,
  input  wire logic        program_enable_voltage_i,
  output logic      [15:0] dq_o,
  output logic             busy_status_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [16];
  logic [15:0] last = 16'h0000;
  logic [7:0]  pend = 8'h00;
  logic        page8 = 1'b0;
  logic        stat_mode = 1'b0;
  logic        abort = 1'b0;
  int          busy_cnt = 0;
  int          clr_cnt = 0;
  wire logic   sel;
  assign sel = reset_powerdown_n_i && (chip_selects_i == 3'h0 ||
    (chip_selects_i[2] && !(&chip_selects_i[1:0])));
  assign busy_status_pin_o = !(busy_cnt != 0 || abort);
  initial begin
    foreach (mem[i]) mem[i] = 16'hffff;
  end
  // the write machine keeps counting whether selected or not
  always @(posedge clk_i) begin
    if (busy_cnt != 0) busy_cnt <= busy_cnt - 1;
  end
  always @(negedge reset_powerdown_n_i) begin
    abort = busy_cnt != 0;
    busy_cnt = 0;
    page8 = 1'b0;
    stat_mode = 1'b0;
    pend = 8'h00;
  end
  always @(posedge reset_powerdown_n_i) abort = 1'b0;
  always @(posedge write_en_n_i) begin
    if (sel && out_en_n_i) take();
  end
  task automatic take();
    logic [7:0] p;
    p = pend;
    pend = 8'h00;
    if (p == 8'h60 && dq_i == 16'h0004) begin
      page8 = addr_i[13];
      stat_mode = 1'b0;
    end else if (p == 8'h40 && program_enable_voltage_i) begin
      mem[addr_i[3:0]] &= dq_i;
      busy_cnt = 40;
      stat_mode = 1'b1;
    end else if (p == 8'h20 && dq_i == 16'h00d0 &&
                 program_enable_voltage_i) begin
      for (int i = 0; i < 4; i++) mem[{addr_i[3:2], i[1:0]}] = 16'hffff;
      busy_cnt = 80;
      stat_mode = 1'b1;
    end else if (p == 8'h00) begin
      if (dq_i inside {16'h0060, 16'h0040, 16'h0020}) pend = dq_i[7:0];
      if (dq_i == 16'h00ff) stat_mode = 1'b0;
      if (dq_i == 16'h0070) stat_mode = 1'b1;
      if (dq_i == 16'h0050) clr_cnt++;
    end
  endtask
  // a floating bus shows the inverse of its last driven value
  always @* begin
    if (sel && !out_en_n_i) begin
      dq_o = stat_mode ? {8'h00, busy_status_pin_o, 7'h00} : mem[addr_i[3:0]];
      last = dq_o;
    end else begin
      dq_o = ~last;
    end
  end
endmodule // nfcb_flash_model

// ==== tb/nfcb_flash_host_tb.sv ====
module nfcb_flash_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic [23:0] addr;
  logic [15:0] dq_o;
  logic [15:0] dq_i;
  logic [2:0]  cs;
  logic        oe_n;
  logic        we_n;
  logic        rp_n;
  logic        program_enable_voltage;
  logic        sts;
  logic [31:0] d;
  int          n_mismatch = 0;
  int          checks = 0;

  always #5 clk_i = ~clk_i;

  nfcb_flash_host DUT (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .flash_addr_o(addr), .flash_dq_o(dq_o), .flash_dq_i(dq_i),
    .flash_dq_oe_n_o(), .chip_selects_o(cs), .out_en_n_o(oe_n),
    .write_en_n_o(we_n), .reset_powerdown_n_o(rp_n),
    .program_enable_o(program_enable_voltage), .busy_status_pin_i(sts));
  nfcb_flash_model u_flash (.clk_i(clk_i), .addr_i(addr), .dq_i(dq_o),
    .chip_selects_i(cs), .out_en_n_i(oe_n), .write_en_n_i(we_n),
    .reset_powerdown_n_i(rp_n), .program_enable_voltage_i(program_enable_voltage),
    .dq_o(dq_i), .busy_status_pin_o(sts));

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  task automatic waitclr(input int b);
    for (int i = 0; i < 400; i++) begin
      rd(nfcb_pkg::REG_STATUS);
      if (d[b] === 1'b0) break;
    end
    check("busy", {15'h0000, d[b]}, 16'h0000);
  endtask
  task automatic cmd(input logic [1:0] op);
    wr(nfcb_pkg::REG_CMD, {30'h0000_0000, op});
    waitclr(nfcb_pkg::ST_BUSY_BIT);
  endtask
  task automatic fw(input logic [23:0] a, input logic [15:0] v);
    wr(nfcb_pkg::REG_ADDR, {8'h00, a});
    wr(nfcb_pkg::REG_WDATA, {16'h0000, v});
    cmd(2'h0);
  endtask
  task automatic fr(input logic [23:0] a);
    wr(nfcb_pkg::REG_ADDR, {8'h00, a});
    cmd(2'h1);
    rd(nfcb_pkg::REG_RDATA);
  endtask

  task automatic t_reset();
    waitclr(nfcb_pkg::ST_BUSY_BIT);
    rd(nfcb_pkg::REG_STATUS);
    check("status", d[15:0], 16'h0000);
    rd(8'h1c);
    check("unmapped", d[15:0], 16'h0000);
    fr(24'h00_0005);
    check("array", d[15:0], 16'hffff);
  endtask
  task automatic t_prog_erase();
    wr(nfcb_pkg::REG_CTRL, 32'h0000_0001);
    fw(24'h00_0005, 16'h0040);
    fw(24'h00_0005, 16'h1234);
    waitclr(nfcb_pkg::ST_DEV_BUSY_BIT);
    fw(24'h00_0005, 16'h0040);
    fw(24'h00_0005, 16'hff0f);
    waitclr(nfcb_pkg::ST_DEV_BUSY_BIT);
    fw(24'h00_0005, 16'h00ff);
    fr(24'h00_0005);
    check("program", d[15:0], 16'h1204);
    fw(24'h00_0004, 16'h0020);
    fw(24'h00_0006, 16'h00d0);
    rd(nfcb_pkg::REG_STATUS);
    check("dev busy", d[15:0] & 16'h000a, 16'h000a);
    waitclr(nfcb_pkg::ST_DEV_BUSY_BIT);
    fw(24'h00_0005, 16'h00ff);
    fr(24'h00_0005);
    check("erase", d[15:0], 16'hffff);
  endtask
  task automatic t_program_enable_voltage_low();
    wr(nfcb_pkg::REG_CTRL, 32'h0000_0000);
    fw(24'h00_0009, 16'h0040);
    fw(24'h00_0009, 16'h0000);
    fw(24'h00_0009, 16'h00ff);
    fr(24'h00_0009);
    check("locked", d[15:0], 16'hffff);
  endtask
  task automatic t_page();
    int n;
    n = u_flash.clr_cnt;
    fw(24'h00_0000, 16'h0070);
    wr(nfcb_pkg::REG_ADDR, 32'h00ab_0000);
    wr(nfcb_pkg::REG_CFG, 32'hffff_ffff);
    cmd(2'h2);
    check("page8", {15'h0000, u_flash.page8}, 16'h0001);
    check("clear", 16'(u_flash.clr_cnt - n), 16'h0001);
    rd(nfcb_pkg::REG_STATUS);
    check("st page8", d[15:0] & 16'h0004, 16'h0004);
    fr(24'h00_0005);
    check("array mode", d[15:0], 16'hffff);
    wr(nfcb_pkg::REG_CFG, 32'h0000_0000);
    cmd(2'h2);
    check("page4", {15'h0000, u_flash.page8}, 16'h0000);
    check("no clear", 16'(u_flash.clr_cnt - n), 16'h0001);
  endtask
  task automatic t_reset_pulse();
    wr(nfcb_pkg::REG_CTRL, 32'h0000_0001);
    wr(nfcb_pkg::REG_CFG, 32'h0000_2000);
    cmd(2'h2);
    fw(24'h00_0008, 16'h0020);
    fw(24'h00_0008, 16'h00d0);
    wr(nfcb_pkg::REG_CMD, 32'h0000_0003);
    rd(nfcb_pkg::REG_STATUS);
    rd(nfcb_pkg::REG_STATUS);
    check("in reset", d[15:0] & 16'h001b, 16'h001b);
    waitclr(nfcb_pkg::ST_BUSY_BIT);
    check("cfg reset", {15'h0000, u_flash.page8}, 16'h0000);
    rd(nfcb_pkg::REG_STATUS);
    check("aborted", d[15:0], 16'h0008);
    fr(24'h00_0000);
    check("array", d[15:0], 16'hffff);
    fw(24'h00_0000, 16'h0070);
    fr(24'h00_0000);
    check("dev status", d[15:0], 16'h0080);
  endtask

  initial begin
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_prog_erase();
    t_program_enable_voltage_low();
    t_page();
    t_reset_pulse();
    wrap_up();
  end
  initial begin
    repeat (30000) @(posedge clk_i);
    n_mismatch++;
    wrap_up();
  end
endmodule // nfcb_flash_host_tb
